/* hw/sfp_flash_seq.sv */
// Program/erase command sequencer of a serial flash, with its SPI intake.
// Assumes mode 0 serial clock on sck_i, the array behind the nvm_* port on
// clk_i, and array_protect_bit_i driven by logic on clk_i.
`timescale 1ns/10ps

// Two-flop synchroniser for a single level; reset value matches the pin's idle level
module sfp_sync #(
  parameter logic RST_VAL_P = 1'b0
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Level in and out
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL_P;
      q_o    <= RST_VAL_P;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : sfp_sync

// Summary of operation
// R1: Program starts only with the write-enable latch set.
// R2: Program is 02h, three address bytes, then data into a page buffer.
// R3: Data past the page end wraps to the start of the same page.
// R4: Beyond 256 data bytes only the last 256 are kept.
// R5: At select rise buffered bytes are programmed; untouched bytes stay FFh.
// R6: Short address, no data or partial byte aborts program.
// R7: Protected array blocks program; back to idle at select rise.
// R8: Program abort for short frame, partial byte or protection clears the latch.
// R9: Busy during programming; latch cleared before program completes.
// R10: Host should poll status instead of waiting the worst-case time.
// R11: A byte failing to program sets the error flag.
// R12: Page erase is 81h; middle address byte picks the page.
// R13: Page erase at select rise sets the page to ones, busy throughout.
// R14: A byte failing page erase sets the error flag.
// R15: 20h is a 4K erase; 52h and D8h are 32K erases.
// R16: Block erase refused while the latch is clear.
// R17: Low address bits ignored per block size; extra bytes discarded.
// R18: Short address or partial byte aborts block erase.
// R19: Protected array blocks block erase; back to idle at select rise.
// R20: Block erase abort clears the latch.
// R21: Busy during block erase; latch cleared before it completes.
// R22: A byte failing block erase sets the error flag.
// R23: 06h sets the latch at select rise; writes ignored without it.
// R24: Protect bit set means the whole array refuses program and erase.
// R25: Page erase follows the block erase gating and abort behaviour.
module sfp_flash_seq
  import sfp_pkg::*;
#(
  parameter int unsigned PAGE_PROGRAM_CYC_P        = sfp_pkg::PAGE_PROGRAM_CYC,
  parameter int unsigned SINGLE_BYTE_PROGRAM_CYC_P = sfp_pkg::SINGLE_BYTE_PROGRAM_CYC,
  parameter int unsigned PAGE_ERASE_CYC_P          = sfp_pkg::PAGE_ERASE_CYC,
  parameter int unsigned BLOCK_ERASE_4K_CYC_P      = sfp_pkg::BLOCK_ERASE_4K_CYC,
  parameter int unsigned BLOCK_ERASE_32K_CYC_P     = sfp_pkg::BLOCK_ERASE_32K_CYC
) (
  // Core clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Serial link
  input  wire logic               sck_i,
  input  wire logic               cs_n_i,
  input  wire logic               mosi_i,
  // Protection and status
  input  wire logic               array_protect_bit_i,
  output logic                    busy_o,
  output logic                    write_enable_latch_o,
  output logic                    program_erase_error_flag_o,
  // Array port
  output logic                    nvm_req_o,
  output sfp_pkg::sfp_nvm_op_e    nvm_op_o,
  output logic [sfp_pkg::ADDR_W-1:0] nvm_addr_o,
  output logic [7:0]              nvm_data_o,
  input  wire logic               nvm_fail_i
);

  // ----------------------------------------------------------------------
  // Link domain: bit intake
  // ----------------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] rx_byte_q;
  logic       start_tog_q;
  logic       done_tog_q;

  // Select high clears the bit position so every frame starts on bit 0
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[5:0], mosi_i};
    end
  end

  // Byte held stable for a whole byte time while the core picks it up
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      start_tog_q <= 1'b0;
      done_tog_q  <= 1'b0;
      rx_byte_q   <= 8'h00;
    end else begin
      if (bit_cnt_q == 3'h0) begin
        start_tog_q <= ~start_tog_q;
      end
      if (bit_cnt_q == LINK_LAST_BIT) begin
        done_tog_q <= ~done_tog_q;
        rx_byte_q  <= {shift_q, mosi_i};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crossing into the core domain
  // ----------------------------------------------------------------------
  logic cs_sync, start_sync, done_sync;
  logic cs_prev_q, start_prev_q, done_prev_q;

  // Select idles high, so its synchroniser leaves reset high: no false frame start
  sfp_sync #(.RST_VAL_P(1'b1)) u_sync_cs (.clk_i(clk_i), .rst_i(rst_i), .d_i(cs_n_i),
                                          .q_o(cs_sync));
  sfp_sync u_sync_start (.clk_i(clk_i), .rst_i(rst_i), .d_i(start_tog_q), .q_o(start_sync));
  sfp_sync u_sync_done  (.clk_i(clk_i), .rst_i(rst_i), .d_i(done_tog_q),  .q_o(done_sync));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_prev_q    <= 1'b1;
      start_prev_q <= 1'b0;
      done_prev_q  <= 1'b0;
    end else begin
      cs_prev_q    <= cs_sync;
      start_prev_q <= start_sync;
      done_prev_q  <= done_sync;
    end
  end

  logic frame_on, frame_off, start_edge, done_edge;
  assign frame_on   = cs_prev_q & ~cs_sync;
  assign frame_off  = ~cs_prev_q & cs_sync;
  assign start_edge = start_sync ^ start_prev_q;
  assign done_edge  = done_sync ^ done_prev_q;

  // ----------------------------------------------------------------------
  // Core domain: command intake
  // ----------------------------------------------------------------------
  sfp_state_e      state_q;
  logic [2:0]      settle_q;
  logic [2:0]      byte_cnt_q;
  logic [7:0]      opcode_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]      wr_idx_q;
  logic [1:0]      data_cnt_q;
  logic            open_q;
  logic [PAGE_BYTES-1:0] loaded_q;
  logic [7:0]      page_buf [PAGE_BYTES];
  logic [7:0]      idx_q;
  logic [31:0]     timer_q;
  logic            wel_q;
  logic            err_q;

  logic take_byte, take_data, decide;
  assign take_byte = done_edge & ((state_q == ST_FRAME) | (state_q == ST_SETTLE));
  assign take_data = take_byte & (byte_cnt_q >= MIN_BYTES_ERASE) & (opcode_q == OPC_PROGRAM);
  assign decide    = (state_q == ST_SETTLE) & (settle_q == SETTLE_CYC);

  logic is_prog, is_perase, is_e4k, is_e32k, is_erase, is_we;
  assign is_prog   = opcode_q == OPC_PROGRAM;                                     // R2
  assign is_perase = opcode_q == OPC_PAGE_ERASE;                                  // R12
  assign is_e4k    = opcode_q == OPC_ERASE_4K;                                    // R15
  assign is_e32k   = (opcode_q == OPC_ERASE_32K_A) | (opcode_q == OPC_ERASE_32K_B); // R15
  assign is_erase  = is_perase | is_e4k | is_e32k;
  assign is_we     = opcode_q == OPC_WRITE_ENABLE;

  logic complete, exec, abort_clear;
  // R6 R18
  assign complete    = ~open_q &
                       (byte_cnt_q >= (is_prog ? MIN_BYTES_PROG : MIN_BYTES_ERASE));
  // R1 R16 R7 R19 R24 R25
  assign exec        = (is_prog | is_erase) & wel_q & complete & ~array_protect_bit_i;
  // R8 R20 R25
  assign abort_clear = (is_prog | is_erase) & wel_q & ~exec;

  // Partial byte tracking; a new byte start wins over the last byte's end
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_q == ST_IDLE)) begin
      open_q <= 1'b0;
    end else if (start_edge) begin
      open_q <= 1'b1;
    end else if (done_edge) begin
      open_q <= 1'b0;
    end
  end

  // Opcode, address and byte counting
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_q == ST_IDLE)) begin
      byte_cnt_q <= 3'h0;
      opcode_q   <= 8'h00;
      addr_q     <= '0;
      wr_idx_q   <= 8'h00;
      data_cnt_q <= 2'h0;
    end else if (take_byte) begin
      if (byte_cnt_q != BYTE_CNT_MAX) begin
        byte_cnt_q <= byte_cnt_q + 3'h1;
      end
      case (byte_cnt_q)
        BYTE_OPCODE:   opcode_q <= rx_byte_q;
        BYTE_ADDR_HI:  addr_q[16] <= rx_byte_q[0];
        BYTE_ADDR_MID: addr_q[15:8] <= rx_byte_q;
        BYTE_ADDR_LO: begin
          addr_q[7:0] <= rx_byte_q;
          wr_idx_q    <= rx_byte_q;
        end
        default: begin
          if (take_data) begin
            wr_idx_q <= wr_idx_q + 8'h01;                                          // R3 R4
            if (data_cnt_q != 2'h2) begin
              data_cnt_q <= data_cnt_q + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // Page buffer: later bytes overwrite earlier ones at the same offset
  always_ff @(posedge clk_i) begin
    if (take_data) begin
      page_buf[wr_idx_q] <= rx_byte_q;                                             // R2 R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (state_q == ST_IDLE)) begin
      loaded_q <= '0;
    end else if (take_data) begin
      loaded_q[wr_idx_q] <= 1'b1;                                                  // R5
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= ST_IDLE;
      settle_q <= 3'h0;
      idx_q    <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (frame_on) begin
            state_q <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          settle_q <= 3'h0;
          if (frame_off) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          settle_q <= settle_q + 3'h1;
          if (decide) begin
            idx_q <= 8'h00;
            if (!exec) begin
              state_q <= ST_IDLE;                                                  // R7 R19
            end else if (is_prog) begin
              state_q <= ST_WRITE;                                                 // R5
            end else begin
              state_q <= ST_WAIT;                                                  // R13
            end
          end
        end
        ST_WRITE: begin
          idx_q <= idx_q + 8'h01;
          if (idx_q == LAST_IDX) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (timer_q == 32'h0) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Self-timed wait, length picked by the command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_q <= 32'h0;
    end else if (decide && exec) begin
      if (is_prog) begin
        timer_q <= (data_cnt_q == 2'h1) ? 32'(SINGLE_BYTE_PROGRAM_CYC_P)
                                         : 32'(PAGE_PROGRAM_CYC_P);
      end else if (is_perase) begin
        timer_q <= 32'(PAGE_ERASE_CYC_P);
      end else if (is_e4k) begin
        timer_q <= 32'(BLOCK_ERASE_4K_CYC_P);
      end else begin
        timer_q <= 32'(BLOCK_ERASE_32K_CYC_P);
      end
    end else if ((state_q == ST_WAIT) && (timer_q != 32'h0)) begin
      timer_q <= timer_q - 32'h1;
    end
  end

  // Array requests: one per loaded page byte, or one erase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvm_req_o  <= 1'b0;
      nvm_op_o   <= NVM_PROGRAM;
      nvm_addr_o <= '0;
      nvm_data_o <= ERASED_BYTE;
    end else if (state_q == ST_WRITE) begin
      nvm_req_o  <= loaded_q[idx_q];                                               // R5
      nvm_op_o   <= NVM_PROGRAM;
      nvm_addr_o <= {addr_q[16:8], idx_q};                                         // R3
      nvm_data_o <= page_buf[idx_q];
    end else if (decide && exec && is_erase) begin
      nvm_req_o  <= 1'b1;
      nvm_data_o <= ERASED_BYTE;
      if (is_perase) begin
        nvm_op_o   <= NVM_ERASE_PAGE;
        nvm_addr_o <= {1'b0, addr_q[15:8], PAGE_OFFSET_ZERO};                     // R12
      end else if (is_e4k) begin
        nvm_op_o   <= NVM_ERASE_4K;
        nvm_addr_o <= addr_q & KEEP_4K;                                            // R17
      end else begin
        nvm_op_o   <= NVM_ERASE_32K;
        nvm_addr_o <= addr_q & KEEP_32K;                                           // R17
      end
    end else begin
      nvm_req_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (decide && exec) begin
      busy_o <= 1'b1;                                                              // R9 R13 R21
    end else if ((state_q == ST_WAIT) && (timer_q == 32'h0)) begin
      busy_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wel_q <= 1'b0;
    end else if (decide && is_we && !open_q && (byte_cnt_q >= MIN_BYTES_WE)) begin
      wel_q <= 1'b1;                                                               // R23
    end else if (decide && (exec || abort_clear)) begin
      wel_q <= 1'b0;                                                               // R8 R9 R20 R21
    end
  end
  assign write_enable_latch_o = wel_q;

  // A failure reported while busy wins over the clear at the next start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
    end else if (busy_o && nvm_fail_i) begin
      err_q <= 1'b1;                                                               // R11 R14 R22
    end else if (decide && exec) begin
      err_q <= 1'b0;
    end
  end
  assign program_erase_error_flag_o = err_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_exec_erase;
    decide && exec && is_erase;
  endsequence

  property p_no_exec_without_wel;
    decide && !wel_q |=> !busy_o && !nvm_req_o;
  endproperty
  a_no_exec_without_wel: assert property (p_no_exec_without_wel) // R1
    else $error("command executed with latch clear");

  property p_wrap_index;
    take_data |=> wr_idx_q == 8'($past(wr_idx_q) + 8'h01);
  endproperty
  a_wrap_index: assert property (p_wrap_index) // R3
    else $error("page buffer index did not wrap");

  property p_untouched_skipped;
    state_q == ST_WRITE |=> nvm_req_o == $past(loaded_q[idx_q]);
  endproperty
  a_untouched_skipped: assert property (p_untouched_skipped) // R5
    else $error("unloaded page byte was programmed");

  property p_partial_aborts;
    decide && open_q |=> !busy_o ##1 !nvm_req_o;
  endproperty
  a_partial_aborts: assert property (p_partial_aborts) // R6
    else $error("partial byte did not abort");

  property p_protect_blocks;
    decide && array_protect_bit_i |=> state_q == ST_IDLE && !busy_o;
  endproperty
  a_protect_blocks: assert property (p_protect_blocks) // R24
    else $error("protected array was written");

  property p_abort_clears_wel;
    decide && abort_clear |=> !wel_q;
  endproperty
  a_abort_clears_wel: assert property (p_abort_clears_wel) // R8
    else $error("latch kept after abort");

  property p_busy_no_wel;
    busy_o |-> !wel_q;
  endproperty
  a_busy_no_wel: assert property (p_busy_no_wel) // R9
    else $error("latch set while busy");

  property p_fail_sets_flag;
    busy_o && nvm_fail_i |=> err_q;
  endproperty
  a_fail_sets_flag: assert property (p_fail_sets_flag) // R11
    else $error("failure not flagged");

  property p_erase_request;
    s_exec_erase |=> nvm_req_o && busy_o ##1 !nvm_req_o && busy_o;
  endproperty
  a_erase_request: assert property (p_erase_request) // R13
    else $error("erase did not issue one request while busy");

  property p_block_align;
    nvm_req_o && nvm_op_o == NVM_ERASE_32K |-> (nvm_addr_o & ~KEEP_32K) == '0;
  endproperty
  a_block_align: assert property (p_block_align) // R17
    else $error("32K erase address not aligned");

  property p_we_sets;
    decide && is_we && !open_q |=> wel_q;
  endproperty
  a_we_sets: assert property (p_we_sets) // R23
    else $error("write enable did not set latch");

endmodule : sfp_flash_seq

/* hw/sfp_pkg.sv */
// Constants and types shared by the serial flash program/erase sequencer.
// Assumes a 40 MHz core clock and a 17-bit byte address into the array.
package sfp_pkg;

  // ----------------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_PROGRAM      = 8'h02;
  localparam logic [7:0] OPC_PAGE_ERASE   = 8'h81;
  localparam logic [7:0] OPC_ERASE_4K     = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K_A  = 8'h52;
  localparam logic [7:0] OPC_ERASE_32K_B  = 8'hd8;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int         ADDR_W      = 17;
  localparam int         PAGE_BYTES  = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] LAST_IDX    = 8'hff;
  localparam logic [7:0] PAGE_OFFSET_ZERO = 8'h00;
  localparam logic [16:0] KEEP_4K     = 17'h1f000;
  localparam logic [16:0] KEEP_32K    = 17'h18000;
  localparam logic [2:0] BYTE_OPCODE = 3'h0;
  localparam logic [2:0] BYTE_ADDR_HI  = 3'h1;
  localparam logic [2:0] BYTE_ADDR_MID = 3'h2;
  localparam logic [2:0] BYTE_ADDR_LO  = 3'h3;
  localparam logic [2:0] BYTE_CNT_MAX  = 3'h7;
  localparam logic [2:0] MIN_BYTES_WE    = 3'h1;
  localparam logic [2:0] MIN_BYTES_ERASE = 3'h4;
  localparam logic [2:0] MIN_BYTES_PROG  = 3'h5;
  localparam logic [2:0] LINK_LAST_BIT   = 3'h7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ                    = 40;
  localparam int unsigned PAGE_PROGRAM_TIME_US       = 1000;
  localparam int unsigned SINGLE_BYTE_PROGRAM_TIME_US = 10;
  localparam int unsigned PAGE_ERASE_TIME_US         = 2000;
  localparam int unsigned BLOCK_ERASE_4K_TIME_US     = 50000;
  localparam int unsigned BLOCK_ERASE_32K_TIME_US    = 100000;
  localparam int unsigned PAGE_PROGRAM_CYC       = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int unsigned SINGLE_BYTE_PROGRAM_CYC = SINGLE_BYTE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int unsigned PAGE_ERASE_CYC         = PAGE_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned BLOCK_ERASE_4K_CYC     = BLOCK_ERASE_4K_TIME_US * CLK_MHZ;
  localparam int unsigned BLOCK_ERASE_32K_CYC    = BLOCK_ERASE_32K_TIME_US * CLK_MHZ;
  // Cycles waited after select rises so the last byte has crossed over
  localparam logic [2:0] SETTLE_CYC = 3'h3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    NVM_PROGRAM,
    NVM_ERASE_PAGE,
    NVM_ERASE_4K,
    NVM_ERASE_32K
  } sfp_nvm_op_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FRAME,
    ST_SETTLE,
    ST_WRITE,
    ST_WAIT
  } sfp_state_e;

endpackage : sfp_pkg

/* verif/sfp_host_model.sv */
// Serial host model that frames flash commands on a 30 ns serial clock.
// Assumes the device samples mosi on the rising serial edge (mode 0).
`timescale 1ns/10ps
module sfp_host_model (
  // Serial link
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o
);
  // Late update so the link's select-driven clear sees the first rise
  initial begin
    sck_o  <= 1'b0;
    cs_n_o <= 1'b1;
    mosi_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Whole bytes MSB first, then extra bits of a partial byte
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b[$], input int extra);
    logic [7:0] v;
    int         n;
    #7;
    cs_n_o = 1'b0;
    n = b.size() * 8 + extra;
    #30;
    for (int i = 0; i < n; i++) begin
      v = (i / 8 < b.size()) ? b[i / 8] : 8'h5a;
      mosi_o = v[7 - i % 8];
      #15 sck_o = 1'b1;
      #15 sck_o = 1'b0;
    end
    #30 cs_n_o = 1'b1;
    // Released line shows no stale bit
    mosi_o = ~mosi_o;
  endtask : send
endmodule : sfp_host_model

/* verif/testbench.sv */
// Self-checking bench of the program/erase sequencer.
// Assumes a serial host model on the link and a fake array on nvm_*.
`timescale 1ns/10ps
module testbench;
  import sfp_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b0, prot = 1'b0, nvm_fail = 1'b0, inj = 1'b0;
  wire  sck, cs_n, mosi;
  logic busy, write_enable_latch, err, req;
  sfp_nvm_op_e op;
  logic [16:0] addr;
  logic [7:0]  data;
  int n_fail = 0, tests_run = 0, busy_seen = 0;
  logic [16:0] r_addr[$];
  logic [7:0]  r_data[$];
  sfp_nvm_op_e r_op[$];

  always #12.5 clk_i = ~clk_i;

  sfp_host_model host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
  sfp_flash_seq #(.PAGE_PROGRAM_CYC_P(20), .SINGLE_BYTE_PROGRAM_CYC_P(10),
    .PAGE_ERASE_CYC_P(20), .BLOCK_ERASE_4K_CYC_P(20), .BLOCK_ERASE_32K_CYC_P(20)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
    .array_protect_bit_i(prot), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
    .program_erase_error_flag_o(err), .nvm_req_o(req), .nvm_op_o(op),
    .nvm_addr_o(addr), .nvm_data_o(data), .nvm_fail_i(nvm_fail));

  // Fake array fault input, and a log of array requests
  always @(posedge clk_i) nvm_fail <= inj & busy;
  always @(negedge clk_i) begin
    if (busy === 1'b1) busy_seen++;
    if (req === 1'b1) begin
      r_addr.push_back(addr);
      r_data.push_back(data);
      r_op.push_back(op);
    end
  end

  task give_verdict;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : check

  // One frame, then poll busy until the array is done
  task frame(input logic [7:0] b[$], input int extra = 0);
    int i;
    r_addr = {};
    r_data = {};
    r_op = {};
    busy_seen = 0;
    host.send(b, extra);
    repeat (12) @(posedge clk_i);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk_i);
    if (busy !== 1'b0) begin
      n_fail++;
      $display("unexpected at %0t: busy stuck", $time);
      give_verdict;
    end
  endtask : frame

  task wen;
    frame('{OPC_WRITE_ENABLE});
    check(write_enable_latch === 1'b1, "latch not set");
  endtask : wen

  task t_no_latch;
    frame('{OPC_PROGRAM, 8'h00, 8'h00, 8'h10, 8'h55});
    check(busy_seen == 0 && r_op.size() == 0, "ran without latch");
    frame('{OPC_ERASE_4K, 8'h00, 8'h10, 8'h00});
    check(busy_seen == 0 && r_op.size() == 0 && write_enable_latch === 1'b0, "erase without latch");
  endtask : t_no_latch

  task t_wrap;
    wen;
    inj = 1'b1;
    frame('{OPC_PROGRAM, 8'h01, 8'h23, 8'hfe, 8'ha1, 8'ha2, 8'ha3});
    inj = 1'b0;
    check(busy_seen == 277 && write_enable_latch === 1'b0, "busy or latch");
    check(err === 1'b1, "fault not flagged");
    check(r_op.size() == 3 && r_op[0] === NVM_PROGRAM, "count");
    check(r_addr[0] === 17'h12300 && r_data[0] === 8'ha3 && r_addr[1] === 17'h123fe
      && r_data[1] === 8'ha1 && r_addr[2] === 17'h123ff && r_data[2] === 8'ha2, "wrap");
    wen;
    frame('{OPC_PROGRAM, 8'h00, 8'h05, 8'h40, 8'h3c});
    check(r_op.size() == 1 && r_addr[0] === 17'h00540 && r_data[0] === 8'h3c, "single");
    check(busy_seen == 267, "single byte time");
    check(err === 1'b0, "flag not cleared by next program");
  endtask : t_wrap

  task t_long;
    logic [7:0] q[$];
    logic [8:0] n;
    q = '{OPC_PROGRAM, 8'h00, 8'h04, 8'h00};
    for (int i = 0; i < 258; i++) q.push_back(i[8:1]);
    wen;
    frame(q);
    check(r_op.size() == 256, "count");
    for (int k = 0; k < 256 && k < r_op.size(); k++) begin
      n = (k < 2) ? 9'(k + 256) : 9'(k);
      check(r_addr[k] === {9'h004, k[7:0]} && r_data[k] === n[8:1], "kept");
    end
  endtask : t_long

  task t_erase;
    logic [7:0]  oc[4] = '{OPC_PAGE_ERASE, OPC_ERASE_4K, OPC_ERASE_32K_A, OPC_ERASE_32K_B};
    sfp_nvm_op_e eo[4] = '{NVM_ERASE_PAGE, NVM_ERASE_4K, NVM_ERASE_32K, NVM_ERASE_32K};
    logic [16:0] ea[4] = '{17'h0ab00, 17'h1a000, 17'h18000, 17'h18000};
    for (int i = 0; i < 4; i++) begin
      wen;
      inj = (i == 0) || (i == 3);
      frame('{oc[i], 8'h01, 8'hab, 8'hcd, 8'h77});
      check(err === inj, "fault flag");
      inj = 1'b0;
      check(busy_seen > 0 && write_enable_latch === 1'b0, "busy or latch");
      check(r_op.size() == 1 && r_op[0] === eo[i] && r_addr[0] === ea[i]
        && r_data[0] === ERASED_BYTE, "erase");
    end
    check(err === 1'b1, "fault not flagged");
  endtask : t_erase

  task t_abort;
    wen;
    frame('{OPC_PROGRAM, 8'h00, 8'h00, 8'h10, 8'h55}, 3);
    check(r_op.size() == 0 && write_enable_latch === 1'b0, "partial byte");
    wen;
    frame('{OPC_PROGRAM, 8'h00, 8'h00, 8'h10});
    check(r_op.size() == 0 && write_enable_latch === 1'b0, "no data");
    wen;
    frame('{OPC_ERASE_4K, 8'h00, 8'h10});
    check(r_op.size() == 0 && write_enable_latch === 1'b0, "short");
    wen;
    frame('{OPC_PAGE_ERASE, 8'h00, 8'h10, 8'h00}, 5);
    check(r_op.size() == 0 && write_enable_latch === 1'b0, "page partial");
  endtask : t_abort

  task t_prot;
    @(posedge clk_i) prot <= 1'b1;
    wen;
    frame('{OPC_ERASE_32K_B, 8'h00, 8'h10, 8'h00});
    check(busy_seen == 0 && r_op.size() == 0 && write_enable_latch === 1'b0, "erase");
    wen;
    frame('{OPC_PROGRAM, 8'h00, 8'h00, 8'h10, 8'h55});
    check(busy_seen == 0 && r_op.size() == 0 && write_enable_latch === 1'b0, "program");
    @(posedge clk_i) prot <= 1'b0;
  endtask : t_prot

  initial begin
    // Late update gives the link-side reset a real rising edge
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_no_latch;
    t_wrap;
    t_long;
    t_erase;
    t_abort;
    t_prot;
    give_verdict;
  end
endmodule : testbench
